// [verilog/icsp_map.svh]
// register map, field positions and reset values of the interrupt control block
// assumes a 32-bit apb slave with byte addresses on a 12-bit offset
`ifndef ICSP_MAP_SVH
`define ICSP_MAP_SVH

`define ICSP_ADDR_W        12
`define ICSP_CTRL_OFS      12'h000
`define ICSP_STAT_OFS      12'h004
`define ICSP_RELOAD_OFS    12'h008
`define ICSP_EVT_OFS       12'h00C
`define ICSP_MASK_OFS      12'h010
`define ICSP_PRIO_OFS      12'h014

`define ICSP_MULTI_VECTOR_SELECT_BIT      12
`define ICSP_TPC_MSB       10
`define ICSP_TPC_LSB       8
`define ICSP_POL_LSB       0
`define ICSP_LVL_MSB       10
`define ICSP_LVL_LSB       8
`define ICSP_VEC_MSB       5
`define ICSP_VEC_LSB       0
`define ICSP_EVT_EDGE_BIT  0
`define ICSP_EVT_EXP_BIT   1
`define ICSP_EVT_W         2

`define ICSP_CTRL_RST      32'h00000000
`define ICSP_STAT_RST      32'h00000000
`define ICSP_RELOAD_RST    32'h00000000
`define ICSP_EVT_RST       2'h0
`define ICSP_MASK_RST      2'h0
`define ICSP_PRIO_RST      32'h00000000
`define ICSP_VEC_BASE      6'h01

`endif

// [verilog/icsp_pkg.sv]
// types shared by the interrupt control block
// assumes icsp_map.svh supplies the constants
package icsp_pkg;

  typedef enum logic [1:0] {
    ICSP_TMR_IDLE = 2'b00,
    ICSP_TMR_RUN  = 2'b01
  } icsp_tmr_state_e;

  typedef logic [2:0] icsp_prio_t;
  typedef logic [5:0] icsp_vec_t;

  // a source of level p starts or is held by the timer under threshold t
  function automatic logic icsp_qualifies(input icsp_prio_t p, input icsp_prio_t t);
    return (t != 3'h0) && (p != 3'h0) && (p <= t);
  endfunction

endpackage

// [verilog/icsp_prox_timer.sv]
// proximity timer: loads the reload value on start and counts down to zero
// assumes start is a one-cycle strobe from the owner, qualified by clock enable
`timescale 1ns/1ps
module icsp_prox_timer
  import icsp_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        start_in,
  input  wire logic [31:0] reload_in,
  output logic             running_out,
  output logic             expire_out,
  output logic [31:0]      count_out
);

  icsp_tmr_state_e state_q, state_d;
  logic [31:0]     cnt_q, cnt_d;
  logic            exp_q, exp_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    exp_d   = 1'b0;
    case (state_q)
      ICSP_TMR_IDLE: begin
        if (start_in && reload_in != 32'h0) begin
          cnt_d   = reload_in;                       // RL9
          state_d = ICSP_TMR_RUN;
        end
      end
      ICSP_TMR_RUN: begin
        cnt_d = cnt_q - 32'h1;                       // RL12
        if (cnt_q == 32'h1) begin
          state_d = ICSP_TMR_IDLE;
          exp_d   = 1'b1;
        end
      end
      default: begin
        state_d = ICSP_TMR_IDLE;
        cnt_d   = 32'h0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ICSP_TMR_IDLE;
      cnt_q   <= 32'h0;
      exp_q   <= 1'b0;
    end else if (ce_in) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      exp_q   <= exp_d;
    end
  end

  assign running_out = (state_q == ICSP_TMR_RUN);
  assign expire_out  = exp_q;
  assign count_out   = cnt_q;

endmodule // icsp_prox_timer

// [verilog/icsp_top.sv]
// interrupt control, status and proximity timer with an apb register slave
// assumes external inputs are synchronous to mclk_in; core acks the presented request
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "icsp_map.svh"

// How it works
// RL1 - control bit 12 selects multi vector mode
// RL2 - threshold N 2..7: priority N or lower starts timer
// RL3 - threshold one: only priority 1 starts timer
// RL4 - threshold zero disables the proximity timer
// RL5 - per input polarity: one rising, zero falling
// RL6 - status bits 10-8 show presented priority level
// RL7 - status bits 5-0 show presented vector number
// RL8 - software trusts status only in single vector
// RL9 - timer loads 32-bit reload value when triggered
// RL10 - unimplemented control and status bits read zero
// RL11 - priority fields 1..7, zero disables the source
// RL12 - timer counts down, holds qualifying interrupts meanwhile
module icsp_top
  import icsp_pkg::*;
#(
  parameter int NUM_EXT = 5
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    ce_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [`ICSP_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic [31:0]                  prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire logic [NUM_EXT-1:0]      ext_irq_in,
  input  wire logic                    core_irq_ack_in,
  output logic                         core_irq_req_out,
  output logic [5:0]                   core_irq_vector_out,
  output logic [2:0]                   core_irq_level_out,
  output logic                         irq_out
);

  localparam int IW = (NUM_EXT > 1) ? $clog2(NUM_EXT) : 1;
  localparam int PW = NUM_EXT * 3;
  localparam logic [31:0] CTRL_RST = `ICSP_CTRL_RST;
  localparam logic [31:0] STAT_RST = `ICSP_STAT_RST;
  localparam logic [31:0] PRIO_RST = `ICSP_PRIO_RST;

  function automatic icsp_vec_t src_vec(input logic [IW-1:0] idx);
    return `ICSP_VEC_BASE + 6'(idx);
  endfunction

  // control and configuration registers
  logic               multi_vector_select_q, multi_vector_select_d;
  icsp_prio_t         proximity_threshold_q, proximity_threshold_d;
  logic [NUM_EXT-1:0] ext_irq_polarity_q, ext_irq_polarity_d;
  logic [31:0]        proximity_reload_value_q, proximity_reload_value_d;
  logic [PW-1:0]      src_prio_q, src_prio_d;
  icsp_prio_t         presented_priority_level_q, presented_priority_level_d;
  icsp_vec_t          presented_vector_number_q, presented_vector_number_d;
  logic [`ICSP_EVT_W-1:0] evt_q, evt_d, mask_q, mask_d;
  logic               irq_q, irq_d;

  // apb slave state
  logic [31:0] prdata_q, prdata_d, rd_mux;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        setup, access, mapped;
  logic        wr_ctrl, wr_stat, wr_reload, wr_evt, wr_mask, wr_prio;

  // source and presentation state
  logic [NUM_EXT-1:0] ext_prev_q, pend_q, pend_d, edge_hit, elig, qual, ack_clr;
  logic [NUM_EXT-1:0] prio_one;
  logic               req_q, req_d;
  logic [IW-1:0]      sel_q, sel_d, best_idx;
  icsp_prio_t         best_lvl;
  icsp_vec_t          cvec_q, cvec_d;
  icsp_prio_t         clvl_q, clvl_d;
  logic               tmr_start, tmr_running, tmr_expire;
  logic [31:0]        tmr_count;

  function automatic icsp_prio_t prio_of(input logic [PW-1:0] p, input int i);
    return p[i*3 +: 3];
  endfunction

  assign setup  = psel_in && !penable_in;
  assign access = psel_in && penable_in && pready_q;
  assign mapped = (paddr_in == `ICSP_CTRL_OFS) || (paddr_in == `ICSP_STAT_OFS) ||
                  (paddr_in == `ICSP_RELOAD_OFS) || (paddr_in == `ICSP_EVT_OFS) ||
                  (paddr_in == `ICSP_MASK_OFS) || (paddr_in == `ICSP_PRIO_OFS);
  assign wr_ctrl   = access && pwrite_in && (paddr_in == `ICSP_CTRL_OFS);
  assign wr_stat   = access && pwrite_in && (paddr_in == `ICSP_STAT_OFS);
  assign wr_reload = access && pwrite_in && (paddr_in == `ICSP_RELOAD_OFS);
  assign wr_evt    = access && pwrite_in && (paddr_in == `ICSP_EVT_OFS);
  assign wr_mask   = access && pwrite_in && (paddr_in == `ICSP_MASK_OFS);
  assign wr_prio   = access && pwrite_in && (paddr_in == `ICSP_PRIO_OFS);

  // read multiplexer; unimplemented bits stay zero
  always_comb begin
    rd_mux = 32'h0;
    case (paddr_in)
      `ICSP_CTRL_OFS: begin
        rd_mux[`ICSP_MULTI_VECTOR_SELECT_BIT] = multi_vector_select_q;                          // RL10
        rd_mux[`ICSP_TPC_MSB:`ICSP_TPC_LSB] = proximity_threshold_q;
        rd_mux[`ICSP_POL_LSB +: NUM_EXT] = ext_irq_polarity_q;
      end
      `ICSP_STAT_OFS: begin
        rd_mux[`ICSP_LVL_MSB:`ICSP_LVL_LSB] = presented_priority_level_q;        // RL10
        rd_mux[`ICSP_VEC_MSB:`ICSP_VEC_LSB] = presented_vector_number_q;
      end
      `ICSP_RELOAD_OFS: rd_mux = proximity_reload_value_q;
      `ICSP_EVT_OFS:    rd_mux[`ICSP_EVT_W-1:0] = evt_q;
      `ICSP_MASK_OFS:   rd_mux[`ICSP_EVT_W-1:0] = mask_q;
      `ICSP_PRIO_OFS:   rd_mux[PW-1:0] = src_prio_q;
      default:          rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    pready_d  = setup;
    pslverr_d = setup && !mapped;
    prdata_d  = (setup && !pwrite_in) ? rd_mux : 32'h0;
    multi_vector_select_d = wr_ctrl ? pwdata_in[`ICSP_MULTI_VECTOR_SELECT_BIT] : multi_vector_select_q; // RL1
    proximity_threshold_d = wr_ctrl ? pwdata_in[`ICSP_TPC_MSB:`ICSP_TPC_LSB]
                                    : proximity_threshold_q;
    ext_irq_polarity_d = wr_ctrl ? pwdata_in[`ICSP_POL_LSB +: NUM_EXT] : ext_irq_polarity_q;
    proximity_reload_value_d = wr_reload ? pwdata_in : proximity_reload_value_q;
    src_prio_d = wr_prio ? pwdata_in[PW-1:0] : src_prio_q;
    mask_d     = wr_mask ? pwdata_in[`ICSP_EVT_W-1:0] : mask_q;
  end

  // edge detection, pending flags and timer qualification
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      edge_hit[i] = ext_irq_polarity_q[i] ? (ext_irq_in[i] && !ext_prev_q[i])   // RL5
                                          : (!ext_irq_in[i] && ext_prev_q[i]);
      qual[i]     = icsp_qualifies(prio_of(src_prio_q, i), proximity_threshold_q); // RL2 RL3
      ack_clr[i]  = core_irq_ack_in && req_q && (sel_q == IW'(i));
      prio_one[i] = (prio_of(src_prio_q, i) == 3'h1);
    end
    pend_d    = (pend_q & ~ack_clr) | edge_hit;
    tmr_start = |(edge_hit & qual);                                              // RL4
  end

  // highest priority eligible source; held sources wait for the timer
  always_comb begin
    best_idx = '0;
    best_lvl = 3'h0;
    for (int i = 0; i < NUM_EXT; i++) begin
      elig[i] = pend_q[i] && (prio_of(src_prio_q, i) != 3'h0)                   // RL11
                && !(tmr_running && qual[i]);                                   // RL12
      if (elig[i] && prio_of(src_prio_q, i) > best_lvl) begin
        best_lvl = prio_of(src_prio_q, i);
        best_idx = IW'(i);
      end
    end
    req_d  = |elig;
    sel_d  = req_d ? best_idx : sel_q;
    clvl_d = req_d ? best_lvl : 3'h0;
    cvec_d = (req_d && multi_vector_select_q) ? src_vec(best_idx) : 6'h00;      // RL1
    presented_priority_level_d = wr_stat ? pwdata_in[`ICSP_LVL_MSB:`ICSP_LVL_LSB]
                                         : presented_priority_level_q;
    presented_vector_number_d  = wr_stat ? pwdata_in[`ICSP_VEC_MSB:`ICSP_VEC_LSB]
                                         : presented_vector_number_q;
    if (req_d) begin
      presented_priority_level_d = best_lvl;                                     // RL6
      presented_vector_number_d  = src_vec(best_idx);                            // RL7
    end
  end

  // sticky event flags: a new event beats a write-one clear
  always_comb begin
    evt_d = evt_q & ~(wr_evt ? pwdata_in[`ICSP_EVT_W-1:0] : `ICSP_EVT_RST);
    evt_d[`ICSP_EVT_EDGE_BIT] = evt_d[`ICSP_EVT_EDGE_BIT] | (|edge_hit);
    evt_d[`ICSP_EVT_EXP_BIT]  = evt_d[`ICSP_EVT_EXP_BIT] | tmr_expire;
    irq_d = |(evt_d & mask_d);
  end

  icsp_prox_timer u_timer (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .start_in    (tmr_start),
    .reload_in   (proximity_reload_value_q),
    .running_out (tmr_running),
    .expire_out  (tmr_expire),
    .count_out   (tmr_count)
  );

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      multi_vector_select_q      <= CTRL_RST[`ICSP_MULTI_VECTOR_SELECT_BIT];
      proximity_threshold_q      <= CTRL_RST[`ICSP_TPC_MSB:`ICSP_TPC_LSB];
      ext_irq_polarity_q         <= CTRL_RST[`ICSP_POL_LSB +: NUM_EXT];
      proximity_reload_value_q   <= `ICSP_RELOAD_RST;
      src_prio_q                 <= PRIO_RST[PW-1:0];
      presented_priority_level_q <= STAT_RST[`ICSP_LVL_MSB:`ICSP_LVL_LSB];
      presented_vector_number_q  <= STAT_RST[`ICSP_VEC_MSB:`ICSP_VEC_LSB];
      evt_q      <= `ICSP_EVT_RST;
      mask_q     <= `ICSP_MASK_RST;
      irq_q      <= 1'b0;
      prdata_q   <= 32'h0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      ext_prev_q <= '0;
      pend_q     <= '0;
      req_q      <= 1'b0;
      sel_q      <= '0;
      cvec_q     <= 6'h00;
      clvl_q     <= 3'h0;
    end else if (ce_in) begin
      multi_vector_select_q      <= multi_vector_select_d;
      proximity_threshold_q      <= proximity_threshold_d;
      ext_irq_polarity_q         <= ext_irq_polarity_d;
      proximity_reload_value_q   <= proximity_reload_value_d;
      src_prio_q                 <= src_prio_d;
      presented_priority_level_q <= presented_priority_level_d;
      presented_vector_number_q  <= presented_vector_number_d;
      evt_q      <= evt_d;
      mask_q     <= mask_d;
      irq_q      <= irq_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      ext_prev_q <= ext_irq_in;
      pend_q     <= pend_d;
      req_q      <= req_d;
      sel_q      <= sel_d;
      cvec_q     <= cvec_d;
      clvl_q     <= clvl_d;
    end
  end

  assign prdata_out          = prdata_q;
  assign pready_out          = pready_q;
  assign pslverr_out         = pslverr_q;
  assign core_irq_req_out    = req_q;
  assign core_irq_vector_out = cvec_q;
  assign core_irq_level_out  = clvl_q;
  assign irq_out             = irq_q;

  // checks
  sequence s_tmr_trigger;
    ce_in && tmr_start && !tmr_running && (proximity_reload_value_q != 32'h0);
  endsequence

  sequence s_tmr_loaded(logic [31:0] rv);
    tmr_running && (tmr_count == rv);
  endsequence

  property p_single_vec;
    @(posedge mclk_in) disable iff (!rst_b_in)
      $past(ce_in) && !$past(multi_vector_select_q) |-> core_irq_vector_out == 6'h00;
  endproperty
  a_single_vec: assert property (p_single_vec) else $error("vector not zero in single mode"); // RL1

  property p_multi_vec;
    @(posedge mclk_in) disable iff (!rst_b_in)
      $past(ce_in) && $past(multi_vector_select_q) && core_irq_req_out
      |-> core_irq_vector_out == presented_vector_number_q;
  endproperty
  a_multi_vec: assert property (p_multi_vec) else $error("multi vector mismatch"); // RL1 RL7

  property p_tpc_range;
    @(posedge mclk_in) disable iff (!rst_b_in)
      s_tmr_trigger |=> s_tmr_loaded($past(proximity_reload_value_q));
  endproperty
  a_tpc_range: assert property (p_tpc_range) else $error("timer not loaded on trigger"); // RL2 RL9

  property p_tpc_one;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (proximity_threshold_q == 3'h1) && tmr_start
      |-> |(edge_hit & prio_one);
  endproperty
  a_tpc_one: assert property (p_tpc_one) else $error("threshold one start by wrong level"); // RL3

  property p_tpc_off;
    @(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && (proximity_threshold_q == 3'h0) && !tmr_running |=> !tmr_running;
  endproperty
  a_tpc_off: assert property (p_tpc_off) else $error("timer started while disabled"); // RL4

  property p_edge_pol;
    @(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && (ext_irq_polarity_q[0] ? $rose(ext_irq_in[0]) : $fell(ext_irq_in[0]))
      && ext_prev_q[0] != ext_irq_in[0] |=> pend_q[0];
  endproperty
  a_edge_pol: assert property (p_edge_pol) else $error("edge of chosen polarity lost"); // RL5

  property p_level_rpt;
    @(posedge mclk_in) disable iff (!rst_b_in)
      $past(ce_in) && core_irq_req_out |-> presented_priority_level_q == core_irq_level_out;
  endproperty
  a_level_rpt: assert property (p_level_rpt) else $error("status level mismatch"); // RL6

  property p_ctrl_zero;
    @(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && setup && !pwrite_in && (paddr_in == `ICSP_CTRL_OFS)
      |=> prdata_out[31:13] == 19'h0 && prdata_out[11] == 1'b0 && prdata_out[7:5] == 3'h0;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("reserved control bit set"); // RL10

  property p_prio_nonzero;
    @(posedge mclk_in) disable iff (!rst_b_in)
      core_irq_req_out |-> core_irq_level_out != 3'h0;
  endproperty
  a_prio_nonzero: assert property (p_prio_nonzero) else $error("disabled source presented"); // RL11

  property p_hold;
    @(posedge mclk_in) disable iff (!rst_b_in)
      $past(ce_in) && $past(tmr_running) && core_irq_req_out
      |-> !icsp_qualifies(core_irq_level_out, $past(proximity_threshold_q));
  endproperty
  a_hold: assert property (p_hold) else $error("held interrupt presented"); // RL12

  property p_countdown;
    @(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && tmr_running && tmr_count > 32'h1 |=> tmr_count == $past(tmr_count) - 32'h1;
  endproperty
  a_countdown: assert property (p_countdown) else $error("timer did not count down"); // RL12

endmodule // icsp_top

// [bench/icsp_core_model.sv]
// processor core model: acknowledges the interrupt request presented to it
// assumes the controller drives a registered request level and drops it after the ack
`timescale 1ns/1ps
module icsp_core_model #(
  parameter int ACK_GAP = 4
) (
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  input  wire logic ack_en_in,
  input  wire logic req_in,
  output logic      ack_out
);
  int gap_q;

  // the request needs two edges to fall after an ack, so pause before acking again
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      gap_q   <= 0;
    end else if (ack_out) begin
      ack_out <= 1'b0;
      gap_q   <= ACK_GAP;
    end else if (gap_q != 0) begin
      gap_q <= gap_q - 1;
    end else begin
      ack_out <= req_in && ack_en_in;
    end
  end
endmodule // icsp_core_model

// [bench/icsp_top_tb.sv]
// self-checking bench of the interrupt control block over apb
// assumes icsp_top and the core model; clock 50 MHz, clock enable driven by the bench
`timescale 1ns/1ps
`include "icsp_map.svh"
module icsp_top_tb;
  logic        mclk_in;
  logic        rst_b_in;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  ext_irq;
  logic        ack;
  logic        ack_en;
  logic        req;
  logic        irq;
  logic [5:0]  vec;
  logic [2:0]  lvl;
  int          n_errors;
  int          total_checks;
  int          cycles = 0;
  logic [2:0]  tt [6] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h3, 3'h7};
  logic [2:0]  pp [6] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  logic        ee [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  icsp_top uut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ext_irq_in(ext_irq), .core_irq_ack_in(ack), .core_irq_req_out(req),
    .core_irq_vector_out(vec), .core_irq_level_out(lvl), .irq_out(irq)
  );

  icsp_core_model #(.ACK_GAP(5)) core (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ack_en_in(ack_en), .req_in(req), .ack_out(ack)
  );

  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    @(posedge mclk_in);
    while (pready !== 1'b1) begin
      n++;
      @(posedge mclk_in);
    end
    check("wait states", n, 32'h0);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp,
                      input logic experr);
    logic [31:0] rd;
    logic        err;
    xfer(1'b0, a, 32'h0, rd, err);
    check(what, rd, exp);
    check("pslverr", {31'h0, err}, {31'h0, experr});
  endtask

  task automatic set_in(input int i, input logic v);
    @(posedge mclk_in);
    ext_irq[i] <= v;
  endtask

  task automatic wait_req(input logic e, input int n);
    for (int k = 0; k < n && req !== e; k++) @(posedge mclk_in);
    check("request", {31'h0, req}, {31'h0, e});
  endtask

  initial begin
    ext_irq = 5'h00;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ack_en = 1'b0;
    rst_b_in = 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    for (int k = 0; k < 6; k++) rchk("reset value", 12'(4 * k), 32'h0, 1'b0);
    wr(12'h100, 32'hFFFFFFFF);
    rchk("unmapped", 12'h100, 32'h0, 1'b1);
    wr(`ICSP_CTRL_OFS, 32'hFFFFFFFF);
    rchk("control", `ICSP_CTRL_OFS, 32'h0000171F, 1'b0);
    wr(`ICSP_STAT_OFS, 32'hFFFFFFFF);
    rchk("status", `ICSP_STAT_OFS, 32'h0000073F, 1'b0);
    wr(`ICSP_RELOAD_OFS, 32'hA5C35A3C);
    rchk("reload", `ICSP_RELOAD_OFS, 32'hA5C35A3C, 1'b0);
    wr(`ICSP_PRIO_OFS, 32'h000058D1);
    rchk("priority", `ICSP_PRIO_OFS, 32'h000058D1, 1'b0);
    for (int p = 0; p < 2; p++) begin
      wr(`ICSP_CTRL_OFS, p ? 32'h0000101F : 32'h0);
      for (int i = 0; i < 5; i++) begin
        set_in(i, !p);
        repeat (5) @(posedge mclk_in);
        check("wrong edge", {31'h0, req}, 32'h0);
        set_in(i, p);
        wait_req(1'b1, 6);
        check("vector", {26'h0, vec}, p ? 32'(i + 1) : 32'h0);
        check("level", {29'h0, lvl}, 32'(i + 1));
        if (p == 0) rchk("status", `ICSP_STAT_OFS, 32'((i + 1) * 257), 1'b0);
        ack_en <= 1'b1;
        wait_req(1'b0, 20);
        ack_en <= 1'b0;
        set_in(i, !p);
        repeat (5) @(posedge mclk_in);
        check("wrong edge", {31'h0, req}, 32'h0);
      end
    end
    rchk("events", `ICSP_EVT_OFS, 32'h1, 1'b0);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`ICSP_MASK_OFS, 32'h1);
    repeat (2) @(posedge mclk_in);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`ICSP_EVT_OFS, 32'h1);
    repeat (2) @(posedge mclk_in);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(`ICSP_MASK_OFS, 32'h0);
    wr(`ICSP_RELOAD_OFS, 32'd20);
    ack_en <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      wr(`ICSP_EVT_OFS, 32'h3);
      wr(`ICSP_PRIO_OFS, {29'h0, pp[k]});
      wr(`ICSP_CTRL_OFS, 32'h0000101F | {21'h0, tt[k], 8'h00});
      set_in(0, 1'b1);
      repeat (30) @(posedge mclk_in);
      set_in(0, 1'b0);
      rchk("timer start", `ICSP_EVT_OFS, {30'h0, ee[k], 1'b1}, 1'b0);
      wait_req(1'b0, 20);
    end
    wr(`ICSP_RELOAD_OFS, 32'd40);
    wr(`ICSP_PRIO_OFS, 32'h00000013);
    wr(`ICSP_CTRL_OFS, 32'h0000131F);
    wr(`ICSP_EVT_OFS, 32'h3);
    set_in(0, 1'b1);
    repeat (8) @(posedge mclk_in);
    set_in(1, 1'b1);
    repeat (10) @(posedge mclk_in);
    check("held", {31'h0, req}, 32'h0);
    wait_req(1'b1, 60);
    rchk("expired", `ICSP_EVT_OFS, 32'h3, 1'b0);
    wait_req(1'b0, 40);
    // an edge made while the clock enable is low is seen only once it returns
    wr(`ICSP_CTRL_OFS, 32'h0000101F);
    set_in(0, 1'b0);
    repeat (2) @(posedge mclk_in);
    ce <= 1'b0;
    set_in(0, 1'b1);
    repeat (6) @(posedge mclk_in);
    check("frozen", {31'h0, req}, 32'h0);
    ce <= 1'b1;
    wait_req(1'b1, 6);
    check("vector", {26'h0, vec}, 32'h1);
    wait_req(1'b0, 40);
    stop_test();
  end
endmodule // icsp_top_tb
